// File: hw/rcs_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Fetch outside program or protected area resets.
// - Violation clears exec flag until firmware sets.
// - Only flags of actual cause change, except on power-on, brown-out and awake pin reset.
// - Software may clear flags; hardware clears them too.
// - Software may set flags; no reset follows.
// - Resets load program counter with zero.
// - Power-on sets status bits and flag pattern.
// - Power-on or brown-out clears stack flags.
// - Pin reset clears pin flag; sets exec when awake.
// - Pin reset in sleep updates status bits.
// - Watchdog reset clears watchdog flag and TO bit.
// - Watchdog wake clears status, continues next.
// - Interrupt wake continues next or vectors.
// - Reset instruction clears its own flag.
// - Enabled stack overflow sets overflow flag.
// - Enabled stack underflow sets underflow flag.
// - Stack flags set high; others cleared low.
// - Soft enable readable; acts only in mode 01.
// - Ready reads one when detector enabled and ready.
// - Only mode 01 hands control to software.
// - Exec flag is bit 1; rest zero.
module rcs_top (
  // Clock and reset.
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // Register bus.
  input  rcs_pkg::rcs_axi_req_type axi_req,
  output rcs_pkg::rcs_axi_rsp_type axi_rsp,
  // Reset events and core state.
  input  rcs_pkg::rcs_evt_type     evt,
  input  wire logic                external_reset_pin_n,
  input  wire logic                sleeping,
  input  wire logic                global_irq_enable,
  input  wire logic                stack_fault_reset_enable,
  input  wire logic [14:0]         pc_current,
  // Instruction fetch watch.
  input  wire logic                fetch_valid,
  input  wire logic [14:0]         fetch_addr,
  input  wire logic                protected_flash_area_en,
  // Brown-out detector.
  input  wire logic [1:0]          brownout_mode_cfg,
  input  wire logic                bor_detector_ready,
  output logic                     bor_detect_enable,
  // Core control.
  output logic                     core_reset,
  output logic                     pc_load_valid,
  output logic [14:0]              pc_load_value,
  output logic                     ret_push,
  output logic [14:0]              ret_addr
);
  import rcs_pkg::*;

  typedef enum logic {ST_RUN, ST_HOLD} rcs_state_type;

  // Maps a byte address to a register select code.
  function automatic logic [2:0] reg_sel(input logic [15:0] a);
    logic [2:0] s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0)
    begin
      if (a[13:2] == IDX_BOCTL)  s = SEL_BOCTL;
      if (a[13:2] == IDX_CAUSE0) s = SEL_CAUSE0;
      if (a[13:2] == IDX_CAUSE1) s = SEL_CAUSE1;
      if (a[13:2] == IDX_STAT)   s = SEL_STAT;
    end
    if (a[15:14] != 2'h0) s = SEL_NONE;
    return s;
  endfunction : reg_sel

  rcs_state_type state_reg;
  rcs_cause_type cause;
  logic          is_reset;
  logic [3:0]    cnt_reg;
  logic          core_reset_reg;
  logic          pc_load_valid_reg;
  logic [14:0]   pc_load_value_reg;
  logic          ret_push_reg;
  logic [14:0]   ret_addr_reg;
  logic          pin_s1_reg;
  logic          pin_s2_reg;
  logic          pin_s3_reg;
  logic          rdy_s1_reg;
  logic          rdy_s2_reg;
  logic          mem_viol;
  logic [14:0]   pc_plus1;
  logic [7:0]    cause0_reg;
  logic [7:0]    cause0_wr;
  logic [7:0]    cause0_next;
  logic          exec_reg;
  logic          exec_wr;
  logic          exec_next;
  logic          sbor_reg;
  logic          sbor_next;
  logic          to_reg;
  logic          to_next;
  logic          pd_reg;
  logic          pd_next;
  logic          bor_on;
  logic          bor_en_reg;
  logic          rdy_reg;
  logic          awready_reg;
  logic          wready_reg;
  logic          bvalid_reg;
  logic [1:0]    bresp_reg;
  logic          arready_reg;
  logic          rvalid_reg;
  logic [31:0]   rdata_reg;
  logic [1:0]    rresp_reg;
  logic [15:0]   awaddr_reg;
  logic [31:0]   wdata_reg;
  logic          wstrb0_reg;
  logic          wr_fire;
  logic [2:0]    wsel;
  logic [2:0]    rsel;
  logic [31:0]   rd_data;

  // Outputs come straight from registers.
  assign core_reset        = core_reset_reg;
  assign pc_load_valid     = pc_load_valid_reg;
  assign pc_load_value     = pc_load_value_reg;
  assign ret_push          = ret_push_reg;
  assign ret_addr          = ret_addr_reg;
  assign bor_detect_enable = bor_en_reg;
  assign axi_rsp.awready   = awready_reg;
  assign axi_rsp.wready    = wready_reg;
  assign axi_rsp.bvalid    = bvalid_reg;
  assign axi_rsp.bresp     = bresp_reg;
  assign axi_rsp.arready   = arready_reg;
  assign axi_rsp.rvalid    = rvalid_reg;
  assign axi_rsp.rdata     = rdata_reg;
  assign axi_rsp.rresp     = rresp_reg;

  // Synchronises the reset pin and the detector ready level.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
      pin_s3_reg <= 1'b1;
      rdy_s1_reg <= 1'b0;
      rdy_s2_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= external_reset_pin_n;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      rdy_s1_reg <= bor_detector_ready;
      rdy_s2_reg <= rdy_s1_reg;
    end
  end

  // Flags a fetch from outside the valid execution area.
  assign mem_viol = fetch_valid && (fetch_addr >= PROG_WORDS ||
                    (protected_flash_area_en && fetch_addr >= PROT_BASE));
  // Wakes continue, or return from the interrupt vector, at the instruction after the current one.
  assign pc_plus1 = pc_current + 15'h1;

  // Picks the single cause handled this cycle, highest first.
  always_comb
  begin
    cause = C_NONE;
    if (evt.por)
      cause = C_POR;
    else if (evt.bor)
      cause = C_BOR;
    else if (pin_s3_reg && !pin_s2_reg)
      cause = sleeping ? C_PINS : C_PIN;
    else if (state_reg == ST_RUN && mem_viol)
      cause = C_EXEC;
    else if (evt.wdt_timeout)
      cause = C_WDT;
    else if (evt.reset_instr)
      cause = C_INSTR;
    else if (evt.stack_over && stack_fault_reset_enable)
      cause = C_SOVF;
    else if (evt.stack_under && stack_fault_reset_enable)
      cause = C_SUNF;
    else if (state_reg == ST_RUN && sleeping && evt.wdt_wake)
      cause = C_WWAKE;
    else if (state_reg == ST_RUN && sleeping && evt.irq_wake)
      cause = C_IWAKE;
  end

  assign is_reset = !(cause inside {C_NONE, C_WWAKE, C_IWAKE});

  // Software write values; a hardware cause below overrides them.
  assign wr_fire   = !awready_reg && !wready_reg && !bvalid_reg;
  assign wsel      = reg_sel(awaddr_reg);
  assign cause0_wr = (wr_fire && wstrb0_reg && wsel == SEL_CAUSE0) ?
                     (wdata_reg[7:0] & CAUSE0_MASK) : cause0_reg;
  assign exec_wr   = (wr_fire && wstrb0_reg && wsel == SEL_CAUSE1) ?
                     wdata_reg[B_EXEC] : exec_reg;

  // Applies the flag pattern of the cause; other bits keep their value.
  always_comb
  begin
    cause0_next = cause0_wr;
    exec_next   = exec_wr;
    to_next     = to_reg;
    pd_next     = pd_reg;
    sbor_next   = (wr_fire && wstrb0_reg && wsel == SEL_BOCTL) ?
                  wdata_reg[B_SBOR] : sbor_reg;
    case (cause)
      C_POR:
      begin
        cause0_next = CAUSE0_BASE | (cause0_wr & 8'h01);
        exec_next   = 1'b1;
        to_next     = 1'b1;
        pd_next     = 1'b1;
        sbor_next   = 1'b1;
      end
      C_BOR:
      begin
        cause0_next = CAUSE0_BASE | (cause0_wr & 8'h02);
        to_next     = 1'b1;
        pd_next     = 1'b1;
        sbor_next   = 1'b1;
      end
      C_PIN:
      begin
        cause0_next[B_PIN] = 1'b0;
        exec_next          = 1'b1;
      end
      C_PINS:
      begin
        cause0_next[B_PIN] = 1'b0;
        to_next            = 1'b1;
        pd_next            = 1'b0;
      end
      C_EXEC: exec_next = 1'b0;
      C_WDT:
      begin
        cause0_next[B_WDT] = 1'b0;
        to_next            = 1'b0;
      end
      C_INSTR: cause0_next[B_INS] = 1'b0;
      C_SOVF:  cause0_next[B_SOVF] = 1'b1;
      C_SUNF:  cause0_next[B_SUNF] = 1'b1;
      C_WWAKE:
      begin
        to_next = 1'b0;
        pd_next = 1'b0;
      end
      C_IWAKE:
      begin
        to_next = 1'b1;
        pd_next = 1'b0;
      end
      default: ;
    endcase
  end

  // Stores the flags in the same edge that starts the reset hold.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cause0_reg <= CAUSE0_RST;
      exec_reg   <= 1'b1;
      to_reg     <= 1'b1;
      pd_reg     <= 1'b1;
      sbor_reg   <= 1'b1;
    end
    else
    begin
      cause0_reg <= cause0_next;
      exec_reg   <= exec_next;
      to_reg     <= to_next;
      pd_reg     <= pd_next;
      sbor_reg   <= sbor_next;
    end
  end

  // Holds the core in reset, then restarts it at the reset vector.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_reg         <= ST_HOLD;
      cnt_reg           <= RST_HOLD_CYC;
      core_reset_reg    <= 1'b1;
      pc_load_valid_reg <= 1'b0;
      pc_load_value_reg <= RESET_VEC;
      ret_push_reg      <= 1'b0;
      ret_addr_reg      <= RESET_VEC;
    end
    else
    begin
      pc_load_valid_reg <= 1'b0;
      ret_push_reg      <= 1'b0;
      if (is_reset)
      begin
        state_reg      <= ST_HOLD;
        cnt_reg        <= RST_HOLD_CYC;
        core_reset_reg <= 1'b1;
      end
      else
        case (state_reg)
          ST_HOLD:
          begin
            cnt_reg <= cnt_reg - 4'h1;
            if (cnt_reg == 4'h1)
            begin
              state_reg         <= ST_RUN;
              core_reset_reg    <= 1'b0;
              pc_load_valid_reg <= 1'b1;
              pc_load_value_reg <= RESET_VEC;
            end
          end
          ST_RUN:
            if (cause == C_WWAKE || cause == C_IWAKE)
            begin
              pc_load_valid_reg <= 1'b1;
              pc_load_value_reg <= pc_plus1;
              if (cause == C_IWAKE && global_irq_enable)
              begin
                pc_load_value_reg <= IRQ_VEC;
                ret_push_reg      <= 1'b1;
                ret_addr_reg      <= pc_plus1;
              end
            end
          default: state_reg <= ST_RUN;
        endcase
    end
  end

  // Drives the detector enable from the mode and the soft enable.
  always_comb
  begin
    case (brownout_mode_cfg)
      BMODE_ON:  bor_on = 1'b1;
      BMODE_NSL: bor_on = !sleeping;
      BMODE_SW:  bor_on = sbor_reg;
      default:   bor_on = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      bor_en_reg <= 1'b0;
      rdy_reg    <= 1'b0;
    end
    else
    begin
      bor_en_reg <= bor_on;
      rdy_reg    <= bor_en_reg && rdy_s2_reg;
    end
  end

  // Write channels: address and data are taken in either order.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OK;
      awaddr_reg  <= 16'h0000;
      wdata_reg   <= 32'h0000_0000;
      wstrb0_reg  <= 1'b0;
    end
    else
    begin
      if (awready_reg && axi_req.awvalid)
      begin
        awready_reg <= 1'b0;
        awaddr_reg  <= axi_req.awaddr;
      end
      if (wready_reg && axi_req.wvalid)
      begin
        wready_reg <= 1'b0;
        wdata_reg  <= axi_req.wdata;
        wstrb0_reg <= axi_req.wstrb[0];
      end
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (wsel == SEL_NONE) ? RESP_ERR : RESP_OK;
      end
      if (bvalid_reg && axi_req.bready)
      begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Read data; unimplemented bits read as zero.
  assign rsel = reg_sel(axi_req.araddr);
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (rsel)
      SEL_BOCTL:
      begin
        rd_data[B_SBOR] = sbor_reg;
        rd_data[B_RDY]  = rdy_reg;
      end
      SEL_CAUSE0: rd_data[7:0] = cause0_reg;
      SEL_CAUSE1: rd_data[B_EXEC] = exec_reg;
      SEL_STAT:
      begin
        rd_data[B_TO] = to_reg;
        rd_data[B_PD] = pd_reg;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OK;
    end
    else if (arready_reg && axi_req.arvalid)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_data;
      rresp_reg   <= (rsel == SEL_NONE) ? RESP_ERR : RESP_OK;
    end
    else if (rvalid_reg && axi_req.rready)
    begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_quiet;
    !is_reset [*8];
  endsequence

  AST_EXEC_RESET: assert property (
    cause == C_EXEC |=> core_reset_reg && !exec_reg)
    else $error("violation did not reset and clear flag");
  AST_PC_ZERO: assert property (
    $rose(core_reset_reg) ##0 s_quiet ##1 !is_reset ##1 !is_reset
    |=> !core_reset_reg && pc_load_valid_reg && pc_load_value_reg == RESET_VEC)
    else $error("reset release without zero pc load");
  AST_POR_PATTERN: assert property (
    cause == C_POR |=> cause0_reg[7:1] == CAUSE0_BASE[7:1] && exec_reg
                       && to_reg && pd_reg && sbor_reg)
    else $error("power-on pattern wrong");
  AST_BOR_PATTERN: assert property (
    cause == C_BOR |=> !cause0_reg[B_SOVF] && !cause0_reg[B_SUNF]
                       && !cause0_reg[B_BOR] && $stable(cause0_reg[B_POR]))
    else $error("brown-out pattern wrong");
  AST_WDT_FLAGS: assert property (
    cause == C_WDT |=> !cause0_reg[B_WDT] && !to_reg && $stable(pd_reg))
    else $error("watchdog reset flags wrong");
  AST_KEEP: assert property (
    cause == C_NONE && !wr_fire |=> $stable(cause0_reg) && $stable(exec_reg))
    else $error("flag changed without cause");
  AST_SET_NO_RESET: assert property (
    wr_fire && !is_reset && state_reg == ST_RUN |=> !core_reset_reg)
    else $error("software flag write caused reset");
  AST_WAKE_PC: assert property (
    cause == C_WWAKE |=> pc_load_valid_reg && !core_reset_reg
                         && pc_load_value_reg == $past(pc_plus1))
    else $error("watchdog wake did not continue");
  AST_SBOR_MODE: assert property (
    brownout_mode_cfg == BMODE_SW && $stable(brownout_mode_cfg)
    |=> bor_en_reg == $past(sbor_reg))
    else $error("soft enable not steering detector");
  AST_READY: assert property (
    rdy_reg |-> $past(bor_en_reg))
    else $error("ready while detector off");

endmodule : rcs_top

// File: shared/rcs_pkg.sv
package rcs_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_BOCTL  = 12'h18D;
  localparam logic [11:0] IDX_CAUSE0 = 12'h18E;
  localparam logic [11:0] IDX_CAUSE1 = 12'h18F;
  localparam logic [11:0] IDX_STAT   = 12'h190;

  // Register select codes used by the address decoder.
  localparam logic [2:0] SEL_NONE   = 3'h0;
  localparam logic [2:0] SEL_BOCTL  = 3'h1;
  localparam logic [2:0] SEL_CAUSE0 = 3'h2;
  localparam logic [2:0] SEL_CAUSE1 = 3'h3;
  localparam logic [2:0] SEL_STAT   = 3'h4;

  // Field positions.
  localparam int B_SOVF = 7;
  localparam int B_SUNF = 6;
  localparam int B_WDT  = 4;
  localparam int B_PIN  = 3;
  localparam int B_INS  = 2;
  localparam int B_POR  = 1;
  localparam int B_BOR  = 0;
  localparam int B_EXEC = 1;
  localparam int B_SBOR = 7;
  localparam int B_RDY  = 0;
  localparam int B_TO   = 4;
  localparam int B_PD   = 3;

  // Cause register values.
  localparam logic [7:0] CAUSE0_MASK = 8'hDF;
  localparam logic [7:0] CAUSE0_RST  = 8'h1D;
  localparam logic [7:0] CAUSE0_BASE = 8'h1C;

  // Brown-out modes.
  localparam logic [1:0] BMODE_OFF = 2'h0;
  localparam logic [1:0] BMODE_SW  = 2'h1;
  localparam logic [1:0] BMODE_NSL = 2'h2;
  localparam logic [1:0] BMODE_ON  = 2'h3;

  // Program space and sequencing.
  localparam logic [14:0] PROG_WORDS   = 15'h4000;
  localparam logic [14:0] PROT_BASE    = 15'h3F80;
  localparam logic [14:0] RESET_VEC    = 15'h0000;
  localparam logic [14:0] IRQ_VEC      = 15'h0004;
  localparam logic [3:0]  RST_HOLD_CYC = 4'hA;

  // Bus responses.
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [15:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [15:0] araddr;
    logic        rready;
  } rcs_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rcs_axi_rsp_type;

  typedef struct packed {
    logic por;
    logic bor;
    logic wdt_timeout;
    logic wdt_wake;
    logic irq_wake;
    logic reset_instr;
    logic stack_over;
    logic stack_under;
  } rcs_evt_type;

  typedef enum logic [3:0] {
    C_NONE, C_POR, C_BOR, C_PIN, C_PINS, C_EXEC, C_WDT,
    C_INSTR, C_SOVF, C_SUNF, C_WWAKE, C_IWAKE
  } rcs_cause_type;

endpackage : rcs_pkg

// File: testbench/rcs_top_test.sv
`timescale 1ns/1ps
module rcs_top_test;
  import rcs_pkg::*;
  localparam logic [15:0] A_BOR = {2'h0, IDX_BOCTL, 2'h0};
  localparam logic [15:0] A_C0  = {2'h0, IDX_CAUSE0, 2'h0};
  localparam logic [15:0] A_C1  = {2'h0, IDX_CAUSE1, 2'h0};
  localparam logic [15:0] A_ST  = {2'h0, IDX_STAT, 2'h0};
  logic            clk_sys = 1'b0;
  logic            rst_n   = 1'b0;
  rcs_axi_req_type req     = '0;
  rcs_axi_rsp_type rsp;
  rcs_evt_type     evt     = '0;
  logic            pin_n   = 1'b1;
  logic            slp     = 1'b0;
  logic            irq_en  = 1'b0;
  logic            sfre    = 1'b1;
  logic [14:0]     pc_cur  = 15'h0000;
  logic            f_vld   = 1'b0;
  logic [14:0]     f_addr  = 15'h0000;
  logic            prot    = 1'b0;
  logic [1:0]      mode    = BMODE_ON;
  logic            det     = 1'b1;
  logic [3:0]      strb    = 4'hF;
  logic            bde, crst, pcv, push;
  logic [14:0]     pcval, raddr, pc_seen, ra_seen;
  logic            push_seen;
  logic [31:0]     rnd = 32'h4D07;
  logic [7:0]      c0, c1, st;
  logic            sbor = 1'b1;
  logic [31:0]     rd;
  logic [1:0]      rs;
  int              fails = 0;
  int              n_checks = 0;
  int              pc_cnt = 0;

  rcs_top i_rcs_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp), .evt(evt),
    .external_reset_pin_n(pin_n), .sleeping(slp), .global_irq_enable(irq_en),
    .stack_fault_reset_enable(sfre), .pc_current(pc_cur), .fetch_valid(f_vld),
    .fetch_addr(f_addr), .protected_flash_area_en(prot), .brownout_mode_cfg(mode),
    .bor_detector_ready(det), .bor_detect_enable(bde), .core_reset(crst),
    .pc_load_valid(pcv), .pc_load_value(pcval), .ret_push(push), .ret_addr(raddr)
  );

  // The clock toggles every half period of 10 ns.
  always #10 clk_sys = ~clk_sys;

  // Program counter loads are recorded as they pass.
  always @(posedge clk_sys)
  begin
    if (pcv === 1'b1)
    begin
      pc_cnt    <= pc_cnt + 1;
      pc_seen   <= pcval;
      push_seen <= push;
      ra_seen   <= raddr;
    end
  end

  // Steps the random source.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Works out the flags and status after one event.
  function automatic logic [23:0] model(input rcs_cause_type c, input logic [23:0] s);
    logic [7:0] a, b, t;
    {a, b, t} = s;
    case (c)
      C_POR:   {a, b, t} = {7'h0E, a[0], 8'h02, 8'h18};
      C_BOR:   {a, t} = {6'h07, a[1], 1'b0, 8'h18};
      C_PIN:   {a[3], b} = {1'b0, 8'h02};
      C_PINS:  {a[3], t} = {1'b0, 8'h10};
      C_WDT:   {a[4], t[4]} = 2'h0;
      C_WWAKE: t = 8'h00;
      C_IWAKE: t = 8'h10;
      C_INSTR: a[2] = 1'b0;
      C_SOVF:  a[7] = 1'b1;
      C_SUNF:  a[6] = 1'b1;
      C_EXEC:  b = 8'h00;
      default: a = a;
    endcase
    return {a, b, t};
  endfunction : model

  // Compares one value and counts the result.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then stops.
  task automatic results;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  // One register write; address and data are released as each is taken.
  task automatic axi_wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h0, d};
    req.wstrb   <= strb;
    req.bready  <= 1'b1;
    forever
    begin
      @(posedge clk_sys);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid)
      begin
        req.bready <= 1'b0;
        check({30'h0, rsp.bresp}, {30'h0, er});
        break;
      end
    end
  endtask : axi_wr

  // One register read; data and response are taken at the answer edge.
  task automatic axi_rd(input logic [15:0] a);
    @(posedge clk_sys);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    forever
    begin
      @(posedge clk_sys);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid)
      begin
        rd = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd

  // Reads one register and compares data and response.
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
    axi_rd(a);
    check(rd, {24'h0, e});
    check({30'h0, rs}, {30'h0, er});
  endtask : rd_chk

  // Reads all flag registers against the model.
  task automatic regs_chk;
    rd_chk(A_C0, c0, RESP_OK);
    rd_chk(A_C1, c1, RESP_OK);
    rd_chk(A_ST, st, RESP_OK);
    rd_chk(A_BOR, {sbor, 7'h01}, RESP_OK);
  endtask : regs_chk

  // Waits for the next program counter load, or for none.
  // The count n0 is taken before the event, as a wake loads within one cycle.
  task automatic wait_pc(input int n0, input int n_exp, input logic [14:0] e, input logic p);
    for (int i = 0; i < 60 && pc_cnt == n0; i++)
      @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    check(32'(pc_cnt - n0), 32'(n_exp));
    if (n_exp == 1)
    begin
      check({17'h0, pc_seen}, {17'h0, e});
      check({31'h0, push_seen}, {31'h0, p});
      if (p)
        check({17'h0, ra_seen}, {17'h0, pc_cur + 15'h0001});
    end
  endtask : wait_pc

  // Drives one reset or wake event.
  task automatic fire(input rcs_cause_type c, input logic [10:0] ofs);
    @(posedge clk_sys);
    case (c)
      C_POR:   evt.por <= 1'b1;
      C_BOR:   evt.bor <= 1'b1;
      C_WDT:   evt.wdt_timeout <= 1'b1;
      C_WWAKE: evt.wdt_wake <= 1'b1;
      C_IWAKE: evt.irq_wake <= 1'b1;
      C_INSTR: evt.reset_instr <= 1'b1;
      C_SOVF:  evt.stack_over <= 1'b1;
      C_SUNF:  evt.stack_under <= 1'b1;
      C_EXEC:  f_vld <= 1'b1;
      default: pin_n <= 1'b0;
    endcase
    f_addr <= prot ? PROT_BASE + {8'h0, ofs[6:0]} : PROG_WORDS + {4'h0, ofs};
    @(posedge clk_sys);
    evt   <= '0;
    f_vld <= 1'b0;
    repeat (3) @(posedge clk_sys);
    pin_n <= 1'b1;
  endtask : fire

  // Main sequence.
  initial
  begin
    rcs_cause_type c;
    logic          on;
    int            n_pc;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    {c0, c1, st} = {CAUSE0_RST, 8'h02, 8'h18};
    wait_pc(pc_cnt, 1, RESET_VEC, 1'b0);
    regs_chk;
    $display("test reset values done");
    axi_wr(16'h0700, 8'hFF, RESP_ERR);
    rd_chk(16'h0700, 8'h00, RESP_ERR);
    axi_wr(16'h4638, 8'h00, RESP_ERR);
    strb = 4'hE;
    axi_wr(A_C0, 8'h00, RESP_OK);
    strb = 4'hF;
    f_addr <= PROT_BASE;
    f_vld  <= 1'b1;
    @(posedge clk_sys);
    f_vld  <= 1'b0;
    wait_pc(pc_cnt, 0, RESET_VEC, 1'b0);
    axi_wr(A_ST, 8'h00, RESP_OK);
    regs_chk;
    $display("test bus map done");
    for (int k = 0; k < 3; k++)
    begin
      for (int i = 1; i < 12; i++)
      begin
        c    = rcs_cause_type'(i);
        rnd  = lfsr(rnd);
        sbor = rnd[19];
        axi_wr(A_C0, rnd[7:0], RESP_OK);
        axi_wr(A_C1, rnd[15:8], RESP_OK);
        axi_wr(A_BOR, {sbor, 7'h00}, RESP_OK);
        c0 = rnd[7:0] & CAUSE0_MASK;
        c1 = rnd[15:8] & 8'h02;
        check({31'h0, crst}, 32'h0);
        regs_chk;
        slp    <= (c == C_PINS || c == C_WWAKE || c == C_IWAKE);
        sfre   <= (k == 0) | rnd[16];
        irq_en <= rnd[17];
        prot   <= rnd[18];
        pc_cur <= rnd[30:16];
        @(posedge clk_sys);
        n_pc = pc_cnt;
        fire(c, (k == 0) ? 11'h000 : rnd[10:0]);
        on = !((c == C_SOVF || c == C_SUNF) && !sfre);
        check({31'h0, crst}, {31'h0, on && c != C_WWAKE && c != C_IWAKE});
        if (on)
          {c0, c1, st} = model(c, {c0, c1, st});
        if (on && (c == C_POR || c == C_BOR))
          sbor = 1'b1;
        if (c == C_IWAKE && irq_en)
          wait_pc(n_pc, 1, IRQ_VEC, 1'b1);
        else if (c == C_WWAKE || c == C_IWAKE)
          wait_pc(n_pc, 1, pc_cur + 15'h0001, 1'b0);
        else
          wait_pc(n_pc, on ? 1 : 0, RESET_VEC, 1'b0);
        slp <= 1'b0;
        regs_chk;
      end
    end
    $display("test reset causes done");
    for (int m = 0; m < 4; m++)
    begin
      mode <= 2'(m);
      for (int s = 0; s < 2; s++)
      begin
        slp <= s[0];
        axi_wr(A_BOR, {s[0], 7'h00}, RESP_OK);
        repeat (4) @(posedge clk_sys);
        on = (m == 3) || (m == 2 && s == 0) || (m == 1 && s == 1);
        check({31'h0, bde}, {31'h0, on});
        rd_chk(A_BOR, {s[0], 6'h00, on}, RESP_OK);
      end
    end
    mode <= BMODE_ON;
    det  <= 1'b0;
    slp  <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd_chk(A_BOR, 8'h80, RESP_OK);
    $display("test brown-out modes done");
    results;
  end

  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    results;
  end
endmodule : rcs_top_test
